// ---- logic/adc_sync_feature_pkg.sv ----
// Behaviour
// - feature bit0 enables over-range pin, resets one
// - assign bit0 picks core A or B
// - no sync unless master enable set
// - pulses reach divider only with bits 1,0
// - bit2 clear: resync on every pulse
// - bit2 set: first pulse only, rest ignored
// - with bit2 set, divider sync enable self-clears after sync
// - user bit7 lets output-enable pin act
// - user bit3 enables low-rate detect, starts oscillator while encode rate is low
// - user bit2 runs oscillator unconditionally
package adc_sync_feature_pkg;
  localparam logic [12:0] ADDR_CHANNEL_INDEX = 13'h0005;
  localparam logic [12:0] ADDR_CHANNEL_FEATURE = 13'h002A;
  localparam logic [12:0] ADDR_OUTPUT_ASSIGN = 13'h002E;
  localparam logic [12:0] ADDR_SYNC_CTRL = 13'h0100;
  localparam logic [12:0] ADDR_USER_MISC = 13'h0101;
  localparam logic [1:0] CHANNEL_INDEX_RESET = 2'h3;
  localparam logic FEATURE_RESET = 1'h1;
  localparam logic ASSIGN_RESET_A = 1'h0;
  localparam logic ASSIGN_RESET_B = 1'h1;
  localparam logic [2:0] SYNC_CTRL_RESET = 3'h1;
  localparam logic [7:0] USER_MISC_RESET = 8'h88;
  localparam logic [7:0] USER_MISC_MASK = 8'h8D;
  localparam int SYNC_MASTER_BIT = 0;
  localparam int SYNC_DIVIDER_BIT = 1;
  localparam int SYNC_NEXT_ONLY_BIT = 2;
  localparam int USER_OE_PIN_BIT = 7;
  localparam int USER_DETECT_BIT = 3;
  localparam int USER_RUN_OSC_BIT = 2;
  localparam int USER_NO_PULLDOWN_BIT = 0;
  localparam int INSTR_BITS = 16;
  localparam int INSTR_READ_BIT = 15;
endpackage

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // a zero-width synchroniser has nothing to carry
  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one bit");
  end

  // two flops; the first is read only by the second
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ---- logic/adc_sync_feature_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_sync_feature_control (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe_n,
  output logic sdio_pulldown_en,
  input wire logic sync_pin,
  output logic divider_sync,
  input wire logic output_enable_pin_n,
  output logic data_outputs_en,
  input wire logic encode_rate_low,
  output logic low_rate_detect_en,
  output logic low_rate_oscillator,
  output logic over_range_en_a,
  output logic over_range_en_b,
  output logic core_sel_a,
  output logic core_sel_b
);
  logic [5:0] pins_sync;
  logic sclk_s, sel_s, sdio_s, sync_s, oe_pin_s, low_rate_s;
  logic sclk_d, sync_d;
  logic [4:0] instr_cnt;
  logic [2:0] byte_bit;
  logic [14:0] instr_shift;
  logic [6:0] data_shift;
  logic is_read;
  logic [12:0] addr;
  logic [1:0] channel_index;
  logic [1:0] feature;
  logic [1:0] assign_sel;
  logic [2:0] sync_ctrl;
  logic [7:0] user_misc;

  pin_sync #(.WIDTH(6)) u_pin_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .async_in({sclk, !csb_n, sdio_in, sync_pin, output_enable_pin_n, encode_rate_low}),
    .sync_out(pins_sync)
  );
  assign {sclk_s, sel_s, sdio_s, sync_s, oe_pin_s, low_rate_s} = pins_sync;
  // select travels inverted so the cleared synchroniser reads as deselected after reset
  wire csb_s = !sel_s;

  // the shift logic assumes a 16-bit instruction with the read flag on top
  if (adc_sync_feature_pkg::INSTR_BITS != 16
      || adc_sync_feature_pkg::INSTR_READ_BIT != 15) begin : g_bad_instr
    $error("instruction layout does not fit the serial shift logic");
  end

  // serial port event decode
  wire sclk_rise = sclk_s && !sclk_d && !csb_s;
  wire in_instr = (instr_cnt != 5'(adc_sync_feature_pkg::INSTR_BITS));
  wire instr_done = sclk_rise && (instr_cnt == 5'(adc_sync_feature_pkg::INSTR_BITS - 1));
  wire byte_done = sclk_rise && !in_instr && (byte_bit == 3'h7);
  wire [7:0] wr_byte = {data_shift, sdio_s};
  wire wr_strobe = byte_done && !is_read;
  wire wr_index = wr_strobe && (addr == adc_sync_feature_pkg::ADDR_CHANNEL_INDEX);
  wire wr_feature = wr_strobe && (addr == adc_sync_feature_pkg::ADDR_CHANNEL_FEATURE);
  wire wr_assign = wr_strobe && (addr == adc_sync_feature_pkg::ADDR_OUTPUT_ASSIGN);
  wire wr_sync = wr_strobe && (addr == adc_sync_feature_pkg::ADDR_SYNC_CTRL);
  wire wr_user = wr_strobe && (addr == adc_sync_feature_pkg::ADDR_USER_MISC);

  // per-channel fields read from channel A when it is indexed, else B
  wire rd_ch = channel_index[0] ? 1'b0 : 1'b1;

  // readback; open bits read zero
  function automatic logic [7:0] read_reg(
    input logic [12:0] a,
    input logic [1:0] index_bits,
    input logic feat_bit,
    input logic sel_bit,
    input logic [2:0] sync_bits,
    input logic [7:0] user_bits
  );
    begin
      case (a)
        adc_sync_feature_pkg::ADDR_CHANNEL_INDEX: read_reg = {6'h00, index_bits};
        adc_sync_feature_pkg::ADDR_CHANNEL_FEATURE: read_reg = {7'h00, feat_bit};
        adc_sync_feature_pkg::ADDR_OUTPUT_ASSIGN: read_reg = {7'h00, sel_bit};
        adc_sync_feature_pkg::ADDR_SYNC_CTRL: read_reg = {5'h00, sync_bits};
        adc_sync_feature_pkg::ADDR_USER_MISC: read_reg = user_bits;
        default: read_reg = 8'h00;
      endcase
    end
  endfunction
  // every register is an argument, so the wire follows a change of any of them
  wire [7:0] read_data = read_reg(addr, channel_index, feature[rd_ch], assign_sel[rd_ch],
    sync_ctrl, user_misc);

  // sync path qualification
  wire sync_rise = sync_s && !sync_d;
  wire master_en = sync_ctrl[adc_sync_feature_pkg::SYNC_MASTER_BIT];
  wire divider_en = sync_ctrl[adc_sync_feature_pkg::SYNC_DIVIDER_BIT];
  wire next_only = sync_ctrl[adc_sync_feature_pkg::SYNC_NEXT_ONLY_BIT];
  wire pass_sync = sync_rise && master_en && divider_en;
  // one-shot: the divider enable drops with the pulse, so later pulses are blocked
  wire one_shot_done = pass_sync && next_only;

  // edge history flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_d <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      sync_d <= sync_s;
    end
  end

  // instruction and data shifting, address walks down per byte
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      instr_cnt <= 5'h00;
      byte_bit <= 3'h0;
      instr_shift <= 15'h0000;
      data_shift <= 7'h00;
      is_read <= 1'b0;
      addr <= 13'h0000;
    end else if (csb_s) begin
      instr_cnt <= 5'h00;
      byte_bit <= 3'h0;
    end else if (sclk_rise) begin
      if (in_instr) begin
        instr_cnt <= instr_cnt + 5'h01;
        instr_shift <= {instr_shift[13:0], sdio_s};
        if (instr_done) begin
          is_read <= instr_shift[adc_sync_feature_pkg::INSTR_READ_BIT - 1];
          addr <= {instr_shift[11:0], sdio_s};
        end
      end else begin
        byte_bit <= byte_bit + 3'h1;
        data_shift <= wr_byte[6:0];
        if (byte_bit == 3'h7) begin
          addr <= addr - 13'h0001;
        end
      end
    end
  end

  // serial data pin drive during a read data phase
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sdio_out <= 1'b0;
      sdio_oe_n <= 1'b1;
    end else begin
      sdio_out <= read_data[~byte_bit];
      sdio_oe_n <= !(!csb_s && is_read && !in_instr);
    end
  end

  // configuration registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      channel_index <= adc_sync_feature_pkg::CHANNEL_INDEX_RESET;
      feature <= {2{adc_sync_feature_pkg::FEATURE_RESET}};
      assign_sel <= {adc_sync_feature_pkg::ASSIGN_RESET_B, adc_sync_feature_pkg::ASSIGN_RESET_A};
      user_misc <= adc_sync_feature_pkg::USER_MISC_RESET;
    end else begin
      if (wr_index) begin
        channel_index <= wr_byte[1:0];
      end
      if (wr_feature && channel_index[0]) begin
        feature[0] <= wr_byte[0];
      end
      if (wr_feature && channel_index[1]) begin
        feature[1] <= wr_byte[0];
      end
      if (wr_assign && channel_index[0]) begin
        assign_sel[0] <= wr_byte[0];
      end
      if (wr_assign && channel_index[1]) begin
        assign_sel[1] <= wr_byte[0];
      end
      if (wr_user) begin
        user_misc <= wr_byte & adc_sync_feature_pkg::USER_MISC_MASK;
      end
    end
  end

  // sync control; a software write in the same cycle beats the self-clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sync_ctrl <= adc_sync_feature_pkg::SYNC_CTRL_RESET;
    end else if (wr_sync) begin
      sync_ctrl <= wr_byte[2:0];
    end else if (one_shot_done) begin
      sync_ctrl[adc_sync_feature_pkg::SYNC_DIVIDER_BIT] <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      divider_sync <= 1'b0;
      data_outputs_en <= 1'b1;
      low_rate_detect_en <= 1'b0;
      low_rate_oscillator <= 1'b0;
      sdio_pulldown_en <= 1'b1;
      over_range_en_a <= 1'b0;
      over_range_en_b <= 1'b0;
      core_sel_a <= 1'b0;
      core_sel_b <= 1'b0;
    end else begin
      divider_sync <= pass_sync;
      data_outputs_en <= !(user_misc[adc_sync_feature_pkg::USER_OE_PIN_BIT] && oe_pin_s);
      low_rate_detect_en <= user_misc[adc_sync_feature_pkg::USER_DETECT_BIT];
      low_rate_oscillator <= user_misc[adc_sync_feature_pkg::USER_RUN_OSC_BIT]
        || (user_misc[adc_sync_feature_pkg::USER_DETECT_BIT] && low_rate_s);
      sdio_pulldown_en <= !user_misc[adc_sync_feature_pkg::USER_NO_PULLDOWN_BIT];
      over_range_en_a <= feature[0];
      over_range_en_b <= feature[1];
      core_sel_a <= assign_sel[0];
      core_sel_b <= assign_sel[1];
    end
  end
endmodule
`default_nettype wire

// ---- test/adc_sync_feature_control_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_sync_feature_control_asserts (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic csb_n,
  input wire logic sdio_oe_n,
  input wire logic sdio_pulldown_en,
  input wire logic sync_pin,
  input wire logic divider_sync,
  input wire logic output_enable_pin_n,
  input wire logic data_outputs_en,
  input wire logic low_rate_detect_en,
  input wire logic over_range_en_a,
  input wire logic core_sel_a
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [1:0] up;
  // edges since reset release, saturating
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  // chip select idle long enough to pass the synchroniser
  sequence s_idle;
    csb_n [*5];
  endsequence
  AST_DIV_PULSE: assert property (divider_sync |=> !divider_sync)
    else $error("divider pulse too long");
  AST_DIV_CAUSE: assert property (divider_sync |-> $past(sync_pin, 2))
    else $error("divider pulse without sync pin");
  AST_OE_IDLE: assert property (s_idle |-> sdio_oe_n)
    else $error("data pin driven while idle");
  AST_PULLDOWN: assert property (up == 2'h3 && $changed(sdio_pulldown_en) |-> !$past(csb_n))
    else $error("pull-down changed outside a frame");
  AST_OVR: assert property (up == 2'h3 && $changed(over_range_en_a) |-> !$past(csb_n))
    else $error("over-range enable changed outside a frame");
  AST_CORE: assert property (up == 2'h3 && $changed(core_sel_a) |-> !$past(csb_n))
    else $error("core select changed outside a frame");
  AST_DETECT: assert property (up == 2'h3 && $changed(low_rate_detect_en) |-> !$past(csb_n))
    else $error("detector enable changed outside a frame");
  AST_DOUT: assert property ($fell(data_outputs_en) |-> $past(output_enable_pin_n))
    else $error("outputs disabled with pin low");
endmodule
bind adc_sync_feature_control adc_sync_feature_control_asserts watch (.mclk, .reset_n, .csb_n,
  .sdio_oe_n, .sdio_pulldown_en, .sync_pin, .divider_sync, .output_enable_pin_n,
  .data_outputs_en, .low_rate_detect_en, .over_range_en_a, .core_sel_a);
`default_nettype wire

// ---- test/spi_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic mclk,
  input wire logic sdio_out,
  input wire logic sdio_oe_n,
  input wire logic sdio_pulldown_en,
  output logic csb_n = 1'b1,
  output logic sclk = 1'b0,
  output logic sdio_in
);
  logic host_oe = 1'b0;
  logic host_d = 1'b0;
  logic last = 1'b0;
  // shared data pin level; an unpulled floating pin toggles
  assign sdio_in = !sdio_oe_n ? sdio_out : host_oe ? host_d : sdio_pulldown_en ? 1'b0 : ~last;
  always @(posedge mclk) last <= sdio_in;
  // one frame: instruction then one byte, msb first, slow clock
  task automatic xfer(input logic rd_op, input logic [12:0] addr, input logic [7:0] wdata,
    output logic [7:0] rdata);
    logic [23:0] word;
    word = {rd_op, 2'h0, addr, wdata};
    rdata = 8'h00;
    @(posedge mclk) #2 csb_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      repeat (5) @(posedge mclk);
      #2 sclk = 1'b0;
      host_d = word[i];
      host_oe = !(rd_op && i < 8);
      repeat (5) @(posedge mclk);
      #2 sclk = 1'b1;
      if (i < 8) rdata[i] = sdio_in;
    end
    repeat (5) @(posedge mclk);
    #2 sclk = 1'b0;
    host_oe = 1'b0;
    repeat (5) @(posedge mclk);
    #2 csb_n = 1'b1;
    repeat (5) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

// ---- test/adc_sync_feature_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_sync_feature_control_test;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic sync_pin = 1'b0;
  logic output_enable_pin_n = 1'b0;
  logic encode_rate_low = 1'b0;
  wire logic csb_n, sclk, sdio_in, sdio_out, sdio_oe_n, sdio_pulldown_en, divider_sync;
  wire logic data_outputs_en, low_rate_detect_en, low_rate_oscillator;
  wire logic over_range_en_a, over_range_en_b, core_sel_a, core_sel_b;
  wire logic [7:0] pins = {1'b0, sdio_pulldown_en, low_rate_detect_en, low_rate_oscillator,
    over_range_en_a, over_range_en_b, core_sel_a, core_sel_b};
  int err_count = 0;
  int n_tests = 0;
  int pulses = 0;
  int n;
  logic [7:0] rd;
  logic [7:0] v;
  logic [23:0] tab [4] = '{24'h000101, 24'h020303, 24'h010507, 24'h0006FE};
  adc_sync_feature_control dut (.mclk, .reset_n, .sclk, .csb_n, .sdio_in, .sdio_out, .sdio_oe_n,
    .sdio_pulldown_en, .sync_pin, .divider_sync, .output_enable_pin_n, .data_outputs_en,
    .encode_rate_low, .low_rate_detect_en, .low_rate_oscillator, .over_range_en_a,
    .over_range_en_b, .core_sel_a, .core_sel_b);
  spi_host_model host (.mclk, .sdio_out, .sdio_oe_n, .sdio_pulldown_en, .csb_n, .sclk, .sdio_in);
  // clock and divider pulse count
  always #20 mclk = ~mclk;
  always @(posedge mclk) if (divider_sync === 1'b1) pulses <= pulses + 1;
  // byte compare, verdict, bus cycles and sync pulse
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, rd);
  endtask
  task automatic rdr(input logic [12:0] a);
    host.xfer(1'b1, a, 8'h00, rd);
  endtask
  task automatic pulse();
    @(posedge mclk) #2 sync_pin = 1'b1;
    repeat (10) @(posedge mclk);
    #2 sync_pin = 1'b0;
    repeat (10) @(posedge mclk);
  endtask
  // expected pins after a user register write
  function automatic logic [7:0] misc_exp(input logic [7:0] u, input logic r);
    return {1'b0, !u[0], u[3], u[2] | (u[3] & r), 4'hD};
  endfunction
  // main sequence
  initial begin
    v = 8'($urandom(32'hE91A));
    repeat (4) @(posedge mclk);
    #2 reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    #2;
    chk("pins", 8'h6D, pins);
    rdr(13'h100);
    chk("sync", 8'h01, rd);
    rdr(13'h101);
    chk("user", 8'h88, rd);
    rdr(13'h050);
    chk("unmapped", 8'h00, rd);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) #2 output_enable_pin_n = (i == 0) ? 1'b1 : 1'($urandom());
      encode_rate_low = 1'($urandom());
      v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom());
      wr(13'h101, v);
      rdr(13'h101);
      chk("user", v & adc_sync_feature_pkg::USER_MISC_MASK, rd);
      chk("misc", misc_exp(v, encode_rate_low), pins);
      chk("dout", {7'h0, !(v[7] & output_enable_pin_n)}, {7'h0, data_outputs_en});
    end
    wr(13'h005, 8'h01);
    wr(13'h02A, 8'hFE);
    wr(13'h02E, 8'h01);
    rdr(13'h02A);
    chk("feature", 8'h00, rd);
    chk("chan", 8'h07, {4'h0, pins[3:0]});
    wr(13'h005, 8'h02);
    rdr(13'h02E);
    chk("assign", 8'h01, rd);
    for (int i = 0; i < 4; i++) begin
      wr(13'h100, tab[i][7:0]);
      n = pulses;
      pulse();
      pulse();
      chk("pulses", tab[i][23:16], 8'(pulses - n));
      rdr(13'h100);
      chk("sync", tab[i][15:8], rd);
    end
    report_and_stop();
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
